// ### sfcf_frontend.v
// Purpose: serial command framing, decode and ID readout of a serial NOR flash
// Assumes: serial clock slower than clock/4; all pins sampled through two flops
// Notes: single-line output only; write-type commands surface as one-cycle pulses
//        status write bytes are staged and land only when the frame ends cleanly
//        ID values are arbitrary parameters, not tied to any real part
//
// What this block does
// - Bits move MSB first from first rising serial edge after select falls.
// - Opcode bits are captured from serial input on rising serial edges.
// - Frame starts with one opcode byte; address or data bytes may follow.
// - Reads, status read, wake and ID reads have an output data phase.
// - Host may end output after any bit; device stops cleanly.
// - Write-type commands are discarded unless select rises on a byte boundary.
// - Byte boundary means serial edge count is a multiple of eight.
// - Page program with partial final byte runs no command and keeps the latch.
// - Three ID commands report maker, device type and capacity codes.
// - Standard ID returns maker, device type, capacity bytes in order.
// - Maker/device read: two dummies, zero byte, then maker and capacity.
// - Wake opcode alone wakes; after three dummies it returns capacity byte if awake, nothing if asleep.
// - Read and page program carry three address bytes then streamed data.
// - Fast, dual and quad output reads carry address plus one dummy byte.
// - Dual I/O read carries address and mode byte before data.
// - Quad I/O read carries address, mode byte and dummies before data.
// - A frame opening with two FFh bytes leaves continuous read mode.
// - Sector and block erases take three address bytes; chip erase none.
// - Latch set/clear, power-down, suspend, resume, volatile enable are opcode only.
// - Status write carries low then high byte; 05h/35h read low/high.
// - Security erase/program take address; security read adds a dummy.
// - In deep power-down serial output stays off and no opcode but wake runs; quad I/O mode byte and FFh FFh still set/clear cont_read.
// - Program, erase, status and security writes need the latch set.
`timescale 1ns/1ps
`include "sfcf_consts.vh"

module sfcf_frontend #(
   parameter [7:0] MAKER_CODE = 8'hA5,   // Arbitrary value
   parameter [7:0] DEVICE_TYPE = 8'h5A,  // Arbitrary value
   parameter [7:0] CAPACITY_CODE = 8'h3C // Arbitrary value
) (
   // Clock and reset
   input wire clock,
   input wire rst_b,
   // Serial pins
   input wire cs_b,
   input wire sclk,
   input wire si,
   output reg so,
   output reg so_oe,
   // Status and memory side
   input wire [7:0] mem_data,
   output reg [23:0] cmd_addr,
   output reg [7:0] wr_data,
   output reg wr_data_valid,
   output reg [7:0] cmd_op,
   output reg cmd_exec,
   output reg write_enable_latch,
   output reg deep_power_down,
   output reg cont_read,
   output reg [7:0] status_low_byte,
   output reg [7:0] status_high_byte
);

   // One-hot frame phases: opcode, input bytes, output bytes
   localparam [2:0] ST_OPC = 3'b001;
   localparam [2:0] ST_IN = 3'b010;
   localparam [2:0] ST_OUT = 3'b100;

   reg [1:0] cs_sync;
   reg [1:0] sclk_sync;
   reg [1:0] si_sync;
   reg sclk_prev;
   reg cs_prev;
   reg [2:0] state;
   reg [7:0] shreg;
   reg [2:0] bitcnt;
   reg [15:0] bytecnt;
   reg [7:0] opcode;
   reg [7:0] txbyte;
   reg [7:0] prev_byte;
   reg frame_on;
   reg partial;
   reg [15:0] pulse_cnt;
   reg [7:0] stage_low;
   reg [7:0] stage_high;

   wire cs_low = ~cs_sync[1];
   wire rise = sclk_sync[1] & ~sclk_prev;
   wire fall = ~sclk_sync[1] & sclk_prev;
   wire cs_rise = cs_sync[1] & ~cs_prev;
   wire [7:0] next_shreg = {shreg[6:0], si_sync[1]};
   wire byte_done = rise & (bitcnt == 3'd7);

   // Bytes taken in before the output phase starts, by opcode
   reg [15:0] in_len;
   reg is_read;
   reg is_write;
   reg needs_latch;
   always @* begin
      in_len = 16'd0;
      is_read = 1'b0;
      is_write = 1'b0;
      needs_latch = 1'b0;
      case (opcode)
         `SFCF_OP_RDSR_LO, `SFCF_OP_RDSR_HI, `SFCF_OP_JEDEC: begin
            is_read = 1'b1;
         end
         `SFCF_OP_READ: begin
            in_len = 16'd3;
            is_read = 1'b1;
         end
         `SFCF_OP_FREAD, `SFCF_OP_DREAD, `SFCF_OP_QREAD, `SFCF_OP_SECR: begin
            in_len = 16'd4;
            is_read = 1'b1;
         end
         `SFCF_OP_DIO: begin
            in_len = 16'd4;
            is_read = 1'b1;
         end
         `SFCF_OP_QIO: begin
            in_len = 16'd6;
            is_read = 1'b1;
         end
         `SFCF_OP_RDP, `SFCF_OP_MFID: begin
            in_len = 16'd3;
            is_read = 1'b1;
         end
         `SFCF_OP_PP, `SFCF_OP_SECP: begin
            in_len = 16'd3;
            is_write = 1'b1;
            needs_latch = 1'b1;
         end
         `SFCF_OP_SE, `SFCF_OP_BE32, `SFCF_OP_BE64, `SFCF_OP_SECE: begin
            in_len = 16'd3;
            is_write = 1'b1;
            needs_latch = 1'b1;
         end
         `SFCF_OP_WRSR: begin
            in_len = 16'd1;
            is_write = 1'b1;
            needs_latch = 1'b1;
         end
         `SFCF_OP_CE1, `SFCF_OP_CE2: begin
            is_write = 1'b1;
            needs_latch = 1'b1;
         end
         `SFCF_OP_WREN, `SFCF_OP_WRDI, `SFCF_OP_DPD, `SFCF_OP_SUSP, `SFCF_OP_RESM,
         `SFCF_OP_VSR_EN: begin
            is_write = 1'b1;
         end
         default: begin
            in_len = 16'd0;
         end
      endcase
   end

   // Next byte to shift out, chosen from the opcode and output byte index
   reg [7:0] next_tx;
   reg [15:0] out_idx;
   always @* begin
      out_idx = bytecnt - in_len - 16'd1;
      next_tx = 8'h00;
      case (opcode)
         `SFCF_OP_RDSR_LO: next_tx = status_low_byte;
         `SFCF_OP_RDSR_HI: next_tx = status_high_byte;
         `SFCF_OP_JEDEC: begin
            if (out_idx == 16'd0) begin
               next_tx = MAKER_CODE;
            end else if (out_idx == 16'd1) begin
               next_tx = DEVICE_TYPE;
            end else if (out_idx == 16'd2) begin
               next_tx = CAPACITY_CODE;
            end
         end
         `SFCF_OP_MFID: begin
            next_tx = out_idx[0] ? CAPACITY_CODE : MAKER_CODE;
         end
         `SFCF_OP_RDP: next_tx = CAPACITY_CODE;
         default: next_tx = mem_data;
      endcase
   end

   // Write-type commands need a whole number of bytes and enough of them
   wire on_boundary = (pulse_cnt[2:0] == 3'd0) & (bitcnt == 3'd0) & ~partial;
   wire long_enough = (bytecnt > in_len);
   // A write-type frame runs only if whole, long enough, awake and permitted
   wire write_ok = ~deep_power_down & is_write & on_boundary & long_enough &
                   (~needs_latch | write_enable_latch);

   // Pins cross into the clock domain through two flops each
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cs_sync <= 2'b11;
         sclk_sync <= 2'b00;
         si_sync <= 2'b00;
         sclk_prev <= 1'b0;
         cs_prev <= 1'b1;
      end else begin
         cs_sync <= {cs_sync[0], cs_b};
         sclk_sync <= {sclk_sync[0], sclk};
         si_sync <= {si_sync[0], si};
         sclk_prev <= sclk_sync[1];
         cs_prev <= cs_sync[1];
      end
   end

   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_OPC;
         shreg <= 8'h00;
         bitcnt <= 3'd0;
         bytecnt <= 16'd0;
         opcode <= 8'h00;
         txbyte <= 8'h00;
         prev_byte <= 8'h00;
         frame_on <= 1'b0;
         partial <= 1'b0;
         pulse_cnt <= 16'd0;
         stage_low <= 8'h00;
         stage_high <= 8'h00;
         so <= 1'b0;
         so_oe <= 1'b0;
         cmd_addr <= 24'h000000;
         wr_data <= 8'h00;
         wr_data_valid <= 1'b0;
         cmd_op <= 8'h00;
         cmd_exec <= 1'b0;
         write_enable_latch <= 1'b0;
         deep_power_down <= 1'b0;
         cont_read <= 1'b0;
         status_low_byte <= `SFCF_STAT_RST;
         status_high_byte <= `SFCF_STAT_RST;
      end else begin
         cmd_exec <= 1'b0;
         wr_data_valid <= 1'b0;
         if (cs_low) begin
            frame_on <= 1'b1;
            // Count every rising serial edge; byte boundaries fall out of this count
            if (rise) begin
               pulse_cnt <= pulse_cnt + 16'd1;
               shreg <= next_shreg;
               bitcnt <= bitcnt + 3'd1;
               partial <= ~byte_done;
            end
            if (byte_done) begin
               bytecnt <= bytecnt + 16'd1;
               prev_byte <= next_shreg;
               case (state)
                  ST_OPC: begin
                     opcode <= next_shreg;
                     state <= ST_IN;
                  end
                  // Address bytes, status bytes, mode byte and program data
                  ST_IN: begin
                     // Second FFh of a frame that opened with FFh ends continuous read
                     if (cont_read && opcode == `SFCF_OP_CRM_RST && bytecnt == 16'd1 &&
                         prev_byte == `SFCF_OP_CRM_RST &&
                         next_shreg == `SFCF_OP_CRM_RST) begin
                        cont_read <= 1'b0;
                     end
                     if (bytecnt <= 16'd`SFCF_ADDR_BYTES) begin
                        cmd_addr <= {cmd_addr[15:0], next_shreg};
                     end
                     // Status bytes are staged; they land only if the frame ends cleanly
                     if (opcode == `SFCF_OP_WRSR && bytecnt == 16'd1) begin
                        stage_low <= next_shreg;
                     end
                     if (opcode == `SFCF_OP_WRSR && bytecnt == 16'd2) begin
                        stage_high <= next_shreg;
                     end
                     if (opcode == `SFCF_OP_QIO && bytecnt == 16'd4 &&
                         next_shreg[5:4] == 2'b10) begin
                        cont_read <= 1'b1;
                     end
                     if ((opcode == `SFCF_OP_PP || opcode == `SFCF_OP_SECP) &&
                         bytecnt > 16'd`SFCF_ADDR_BYTES && write_enable_latch &&
                         !deep_power_down) begin
                        wr_data <= next_shreg;
                        wr_data_valid <= 1'b1;
                     end
                  end
                  default: begin
                     state <= state;
                  end
               endcase
            end
            // Load the next output byte on the falling edge after the input phase
            if (fall && is_read && !deep_power_down && bitcnt == 3'd0 &&
                bytecnt > in_len) begin
               txbyte <= {next_tx[6:0], 1'b0};
               so <= next_tx[7];
               so_oe <= 1'b1;
               state <= ST_OUT;
            end else if (fall && state == ST_OUT) begin
               so <= txbyte[7];
               txbyte <= {txbyte[6:0], 1'b0};
            end
            // Asleep: keep the output off for every frame but the wake command
            if (deep_power_down && state == ST_IN && opcode != `SFCF_OP_RDP) begin
               so_oe <= 1'b0;
            end
         end else begin
            // Select high: end of frame, output released after any bit
            so_oe <= 1'b0;
            so <= 1'b0;
            state <= ST_OPC;
            bitcnt <= 3'd0;
            bytecnt <= 16'd0;
            partial <= 1'b0;
            pulse_cnt <= 16'd0;
            frame_on <= 1'b0;
            // Frame end: decide once, on the first cycle select is seen high
            if (cs_rise && frame_on && state != ST_OPC) begin
               if (opcode == `SFCF_OP_RDP && on_boundary) begin
                  deep_power_down <= 1'b0;
               end else if (write_ok) begin
                  cmd_op <= opcode;
                  cmd_exec <= 1'b1;
                  if (opcode == `SFCF_OP_WRSR) begin
                     status_low_byte <= stage_low;
                     // A frame with one status byte leaves the high byte alone
                     if (bytecnt > 16'd2) begin
                        status_high_byte <= stage_high;
                     end
                  end
                  if (opcode == `SFCF_OP_WREN) begin
                     write_enable_latch <= 1'b1;
                  end else if (opcode == `SFCF_OP_DPD) begin
                     deep_power_down <= 1'b1;
                  end else if (opcode != `SFCF_OP_SUSP && opcode != `SFCF_OP_RESM &&
                               opcode != `SFCF_OP_VSR_EN) begin
                     write_enable_latch <= 1'b0;
                  end
               end
            end
         end
      end
   end

endmodule // sfcf_frontend

// ### sfcf_consts.vh
// Purpose: constants for the serial flash command front end
// Assumes: included once by sfcf_frontend.v
// Notes: opcodes are the documented instruction codes
`ifndef SFCF_CONSTS_VH
`define SFCF_CONSTS_VH
`define SFCF_OP_WREN 8'h06
`define SFCF_OP_WRDI 8'h04
`define SFCF_OP_RDSR_LO 8'h05
`define SFCF_OP_RDSR_HI 8'h35
`define SFCF_OP_VSR_EN 8'h50
`define SFCF_OP_WRSR 8'h01
`define SFCF_OP_READ 8'h03
`define SFCF_OP_FREAD 8'h0B
`define SFCF_OP_DREAD 8'h3B
`define SFCF_OP_DIO 8'hBB
`define SFCF_OP_QREAD 8'h6B
`define SFCF_OP_QIO 8'hEB
`define SFCF_OP_CRM_RST 8'hFF
`define SFCF_OP_PP 8'h02
`define SFCF_OP_SE 8'h20
`define SFCF_OP_BE32 8'h52
`define SFCF_OP_BE64 8'hD8
`define SFCF_OP_CE1 8'hC7
`define SFCF_OP_CE2 8'h60
`define SFCF_OP_SUSP 8'h75
`define SFCF_OP_RESM 8'h7A
`define SFCF_OP_DPD 8'hB9
`define SFCF_OP_RDP 8'hAB
`define SFCF_OP_MFID 8'h90
`define SFCF_OP_JEDEC 8'h9F
`define SFCF_OP_SECE 8'h44
`define SFCF_OP_SECP 8'h42
`define SFCF_OP_SECR 8'h48
`define SFCF_BYTE_BITS 4'h8
`define SFCF_ADDR_BYTES 3
`define SFCF_STAT_RST 8'h00
`endif

// ### sfcf_checker.sv
// Purpose: port assertions for sfcf_frontend
// Assumes: bound to every sfcf_frontend instance
// Notes: write-type commands show as cmd_exec pulses
`timescale 1ns/1ps
module sfcf_checker (
   // Clock and reset
   input wire clock,
   input wire rst_b,
   // Watched ports
   input wire cs_b,
   input wire so_oe,
   input wire wr_data_valid,
   input wire [7:0] cmd_op,
   input wire cmd_exec,
   input wire write_enable_latch,
   input wire deep_power_down,
   input wire [7:0] status_low_byte
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   exec_after_rise_a: assert property (cmd_exec |-> $past(cs_b, 1) && $past(cs_b, 3))
      else $error("cmd_exec while select low");
   latch_set_a: assert property ($rose(write_enable_latch) |-> cmd_op == 8'h06)
      else $error("latch set by wrong command");
   latch_clear_a: assert property ($fell(write_enable_latch) |-> cmd_op inside {8'h04, 8'h02,
      8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h01, 8'h44, 8'h42}) else $error("latch lost");
   exec_needs_latch_a: assert property (cmd_exec && cmd_op inside {8'h02, 8'h20, 8'h52,
      8'hD8, 8'hC7, 8'h60, 8'h01} |-> $past(write_enable_latch)) else $error("write w/o latch");
   prog_data_latch_a: assert property (wr_data_valid |-> write_enable_latch && !$past(cs_b, 3))
      else $error("program byte without latch or frame");
   out_release_a: assert property ($rose(cs_b) |-> ##[1:8] !so_oe)
      else $error("output still driven after select rise");
   pd_ignore_a: assert property (deep_power_down && $past(deep_power_down) |-> !cmd_exec)
      else $error("command run in power down");
   status_write_a: assert property ($changed(status_low_byte) |-> cmd_op == 8'h01)
      else $error("status changed without status write");
endmodule // sfcf_checker
bind sfcf_frontend sfcf_checker sfcf_checker_i (.clock(clock), .rst_b(rst_b), .cs_b(cs_b),
   .so_oe(so_oe), .wr_data_valid(wr_data_valid), .cmd_op(cmd_op), .cmd_exec(cmd_exec),
   .write_enable_latch(write_enable_latch), .deep_power_down(deep_power_down),
   .status_low_byte(status_low_byte));

// ### sfcf_host.sv
// Purpose: host serial controller model
// Assumes: serial clock period 125 ns, idle low
// Notes: input line flips when released so stale bits never pass
`timescale 1ns/1ps
module sfcf_host (
   // Serial pins
   output logic cs_b,
   output logic sclk,
   output logic si,
   input wire so
);
   initial begin
      cs_b = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
   end
   // Shifts n bits MSB first, collecting so on rising edges
   task automatic shift(input logic [7:0] b, input int n, output logic [7:0] r);
      r = 8'h00;
      for (int k = 7; k > 7 - n; k--) begin
         si = b[k];
         #62.5 sclk = 1'b1;
         r = {r[6:0], so};
         #62.5 sclk = 1'b0;
      end
   endtask
   task automatic start();
      cs_b = 1'b0;
      // Off-grid start keeps every pin change away from the clock edges
      #61.25;
   endtask
   task automatic stop();
      #62.5 cs_b = 1'b1;
      si = ~si;
      #100;
   endtask
endmodule // sfcf_host

// ### sfcf_tb.sv
// Purpose: self-checking bench for sfcf_frontend
// Assumes: host model drives the serial pins
// Notes: reference model tracks latch, power down, status and executed commands
`timescale 1ns/1ps
module tb;
   localparam logic [7:0] MK = 8'hC3; // Arbitrary value
   localparam logic [7:0] DT = 8'h96; // Arbitrary value
   localparam logic [7:0] CP = 8'h2D; // Arbitrary value
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] mem_data = 8'h00;
   wire cs_b, sclk, si, so, so_oe, wr_data_valid, cmd_exec, cont_read;
   wire write_enable_latch, deep_power_down;
   wire [23:0] cmd_addr;
   wire [7:0] wr_data, cmd_op, status_low_byte, status_high_byte;
   wire so_pin = so_oe ? so : 1'bz;
   int fail_count = 0;
   int cmp_count = 0;
   int nexec = 0;
   int cycles = 0;
   int m_exec = 0;
   logic m_wel = 1'b0;
   logic m_dpd = 1'b0;
   logic [7:0] m_slo = 8'h00;
   logic [7:0] m_shi = 8'h00;
   logic [7:0] none[$];
   sfcf_frontend #(.MAKER_CODE(MK), .DEVICE_TYPE(DT), .CAPACITY_CODE(CP)) sfcf_frontend_i (
      .clock(clock), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe),
      .mem_data(mem_data), .cmd_addr(cmd_addr), .wr_data(wr_data), .wr_data_valid(wr_data_valid),
      .cmd_op(cmd_op), .cmd_exec(cmd_exec), .write_enable_latch(write_enable_latch),
      .deep_power_down(deep_power_down), .cont_read(cont_read),
      .status_low_byte(status_low_byte), .status_high_byte(status_high_byte));
   sfcf_host sfcf_host_i (.cs_b(cs_b), .sclk(sclk), .si(si), .so(so_pin));
   initial begin
      forever #2.5 clock = ~clock;
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cmd_exec === 1'b1)
         nexec++;
      if (cycles == 90000) begin
         fail_count++;
         summarize();
      end
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (exp !== got) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic run(input logic [7:0] tx[$], input int tail, input logic [7:0] exp[$]);
      logic [7:0] r;
      logic [7:0] op;
      logic ex;
      op = tx[0];
      sfcf_host_i.start();
      foreach (tx[i])
         sfcf_host_i.shift(tx[i], 8, r);
      foreach (exp[i]) begin
         sfcf_host_i.shift(8'h00, 8, r);
         check("read byte", exp[i], r);
      end
      if (tail > 0)
         sfcf_host_i.shift(8'hFF, tail, r);
      sfcf_host_i.stop();
      repeat (8) @(negedge clock);
      ex = tail == 0 && !m_dpd && (op inside {8'h06, 8'h04, 8'hB9} || m_wel &&
         op inside {8'h02, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h01});
      if (op == 8'hAB)
         m_dpd = 1'b0;
      if (ex) begin
         m_exec++;
         m_wel = op == 8'h06 || op == 8'hB9 && m_wel;
         m_dpd = op == 8'hB9;
         check("opcode", op, cmd_op);
      end
      if (ex && op == 8'h01) begin
         m_slo = tx[1];
         m_shi = tx[2];
      end
      check("executed", m_exec, nexec);
      check("latch", m_wel, write_enable_latch);
      check("power down", m_dpd, deep_power_down);
      check("status low", m_slo, status_low_byte);
      check("status high", m_shi, status_high_byte);
   endtask
   initial begin
      logic [7:0] ops[$];
      logic [7:0] t[$];
      logic [23:0] a;
      logic [7:0] d;
      void'($urandom(32'hCB31));
      repeat (5) @(negedge clock);
      rst_b = 1'b1;
      repeat (4) @(negedge clock);
      run('{8'h9F}, 0, '{MK, DT, CP});
      run('{8'h90, 8'h00, 8'h00, 8'h00}, 0, '{MK, CP});
      run('{8'hAB, 8'h00, 8'h00, 8'h00}, 0, '{CP});
      run('{8'h77}, 0, none);
      ops = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h02};
      foreach (ops[i]) begin
         a = 24'($urandom);
         d = 8'($urandom);
         t = '{ops[i]};
         if (i < 3 || i == 5)
            t = '{ops[i], a[23:16], a[15:8], a[7:0]};
         if (i == 5)
            t.push_back(d);
         run('{8'h06}, 0, none);
         run(t, 0, none);
         if (i < 3 || i == 5)
            check("address", a, cmd_addr);
      end
      check("program byte", d, wr_data);
      run('{8'h06}, 0, none);
      run(t, 3, none);
      run('{8'h04}, 0, none);
      run(t, 0, none);
      d = 8'($urandom);
      a = 24'($urandom);
      run('{8'h06}, 0, none);
      run('{8'h01, d & 8'hFC, a[7:0] & 8'h7F}, 0, none);
      run('{8'h05}, 0, '{m_slo});
      run('{8'h35}, 0, '{m_shi});
      run('{8'hB9}, 0, none);
      run('{8'h06}, 0, none);
      run('{8'hAB}, 0, none);
      ops = '{8'h03, 8'h0B, 8'h3B, 8'h6B, 8'h48};
      foreach (ops[i]) begin
         a = 24'($urandom);
         mem_data = 8'($urandom);
         t = '{ops[i], a[23:16], a[15:8], a[7:0]};
         if (i > 0)
            t.push_back(8'h00);
         run(t, 0, '{mem_data});
      end
      run('{8'hBB, a[23:16], a[15:8], a[7:0], 8'h00}, 0, '{mem_data});
      run('{8'hEB, a[23:16], a[15:8], a[7:0], 8'h20, 8'h00, 8'h00}, 0, '{mem_data});
      check("continuous read", 1, cont_read);
      run('{8'hFF, 8'hFF}, 0, none);
      check("continuous read", 0, cont_read);
      run(t, 3, none);
      summarize();
   end
endmodule // tb
